// ### hw/pmswc_top.sv
// Contract
// - leaving slow mode selects fast divide 1..64
// - fast switch waits for oscillator ready
// - halt with both keep bits zero sleeps
// - sleep stops all clocks except watchdog
// - fast 0 slow 1 stops fast clock
// - both keep bits one keep both
// - fast 1 slow 0 stops slow clock
// - halt preserves memory, registers and ports
// - halt sets power-down, clears timeout flag
// - halt clears watchdog counter
// - wake on port edge, interrupt, watchdog
// - power-down cleared by power-up or clear
// - watchdog wake sets timeout, resets pc/sp
// - enabled port falling edge wakes, resume next
// - masked or stack-full irq resumes after halt
// - serviceable irq vectors at wake-up
// - irq pending at entry cannot wake
// - wake waits for stopped oscillators; code waits only for the selected fast oscillator on fast clock
// - select code 111 chooses slow clock
// - oscillator enable clears then sets ready
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pmswc_top
    import pmswc_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int STAB_CYC = PMSWC_OSC_STAB_CYC,
    parameter int WDT_W = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORT_W-1:0] port_a_in,
    input wire pmswc_irq_t core_irq,
    output pmswc_clk_t clk_ctrl,
    output logic [2:0] sys_clock_divider_select,
    output logic sys_clk_is_slow,
    output logic resume_after_halt,
    output logic irq_take,
    output logic pc_sp_reset
);
    if (PORT_W < 1 || PORT_W > 16) $error("PORT_W out of range");
    if (STAB_CYC < 1) $error("STAB_CYC must be positive");
    if (WDT_W < 8 || WDT_W > 24) $error("WDT_W out of range");

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic aw_hold_r, w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic [7:0] system_clock_control_reg;
    logic [1:0] osc_en_r;
    logic [PORT_W-1:0] port_a_wake_enable;
    logic [7:0] wdtc_r;
    logic power_down_flag, watchdog_timeout_flag;
    logic crystal_fast_osc_ready, internal_fast_osc_ready;
    pmswc_state_t state_r;

    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

    function automatic logic wr_hit(input logic [7:0] off);
        return wr_go && awaddr_r == off;
    endfunction : wr_hit

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_r == PMSWC_SCC_OFF || awaddr_r == PMSWC_OSC_OFF
                    || awaddr_r == PMSWC_PORT_A_WAKE_ENABLE_OFF
                    || awaddr_r == PMSWC_WDT_OFF
                    || awaddr_r == PMSWC_CMD_OFF) begin
                    s_axi_bresp <= 2'b00;
                end else if (awaddr_r == PMSWC_STAT_OFF) begin
                    s_axi_bresp <= 2'b00;
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                if (s_axi_araddr == PMSWC_SCC_OFF) begin
                    s_axi_rdata <= {24'h00_0000, system_clock_control_reg};
                end else if (s_axi_araddr == PMSWC_OSC_OFF) begin
                    s_axi_rdata <= {28'h000_0000, crystal_fast_osc_ready,
                        internal_fast_osc_ready, osc_en_r};
                end else if (s_axi_araddr == PMSWC_STAT_OFF) begin
                    s_axi_rdata <= {26'h000_0000, state_r == PMSWC_HALTED,
                        sys_clk_is_slow, 2'b00, power_down_flag,
                        watchdog_timeout_flag};
                end else if (s_axi_araddr == PMSWC_PORT_A_WAKE_ENABLE_OFF) begin
                    s_axi_rdata <= 32'(port_a_wake_enable);
                end else if (s_axi_araddr == PMSWC_WDT_OFF) begin
                    s_axi_rdata <= {24'h00_0000, wdtc_r};
                end else if (s_axi_araddr == PMSWC_CMD_OFF) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic halt_cmd, clrwdt_cmd;
    assign halt_cmd = wr_hit(PMSWC_CMD_OFF) && wstrb_r[0]
        && wdata_r[PMSWC_CMD_HALT];
    assign clrwdt_cmd = wr_hit(PMSWC_CMD_OFF) && wstrb_r[0]
        && wdata_r[PMSWC_CMD_CLRWDT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_clock_control_reg <= PMSWC_SCC_RST;
            osc_en_r <= PMSWC_OSC_RST;
            port_a_wake_enable <= '0;
            wdtc_r <= PMSWC_WDTC_RST;
        end else if (wr_go && wstrb_r[0]) begin
            if (awaddr_r == PMSWC_SCC_OFF) begin
                system_clock_control_reg <= wdata_r[7:0] & PMSWC_SCC_WMASK;
            end else if (awaddr_r == PMSWC_OSC_OFF) begin
                osc_en_r <= wdata_r[1:0];
            end else if (awaddr_r == PMSWC_PORT_A_WAKE_ENABLE_OFF) begin
                port_a_wake_enable <= wdata_r[PORT_W-1:0];
            end else if (awaddr_r == PMSWC_WDT_OFF) begin
                wdtc_r <= wdata_r[7:0];
            end
        end
    end

    logic fast_keep_in_idle, slow_keep_in_idle, fhs_sel;
    logic [2:0] cks_sel;
    assign fast_keep_in_idle = system_clock_control_reg[PMSWC_FKEEP_BIT];
    assign slow_keep_in_idle = system_clock_control_reg[PMSWC_SKEEP_BIT];
    assign fhs_sel = system_clock_control_reg[PMSWC_FHS_BIT];
    assign cks_sel = system_clock_control_reg[PMSWC_CKS_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // port a falling-edge detect
    logic [PORT_W-1:0] pa_s1_r, pa_s2_r, pa_s3_r;
    logic pa_wake;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_s1_r <= '1;
            pa_s2_r <= '1;
            pa_s3_r <= '1;
        end else begin
            pa_s1_r <= port_a_in;
            pa_s2_r <= pa_s1_r;
            pa_s3_r <= pa_s2_r;
        end
    end
    assign pa_wake = |(pa_s3_r & ~pa_s2_r & port_a_wake_enable);

    ////////////////////////////////////////////////////////////////////////
    // watchdog counter, slow tick derived locally
    logic wdt_enabled;
    logic [WDT_W-1:0] watchdog_counter;
    logic [$clog2(PMSWC_SLOW_DIV)-1:0] slow_div_r;
    logic wdt_ovf;
    assign wdt_enabled = wdtc_r[7:3] == PMSWC_WE_EN;
    assign wdt_ovf = wdt_enabled && slow_div_r == '0 && &watchdog_counter;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_div_r <= '0;
        end else begin
            slow_div_r <= slow_div_r + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_counter <= '0;
        end else if (halt_cmd || clrwdt_cmd) begin
            watchdog_counter <= '0;
        end else if (wdt_enabled && slow_div_r == '0) begin
            watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator ready flags
    logic [$clog2(STAB_CYC+1)-1:0] irc_cnt_r, xtal_cnt_r;
    logic [1:0] osc_run;
    logic [1:0] osc_run_d_r;
    logic fast_run;

    assign fast_run = state_r != PMSWC_HALTED || fast_keep_in_idle;
    assign osc_run = osc_en_r & {2{fast_run}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_run_d_r <= 2'b00;
            irc_cnt_r <= '0;
            xtal_cnt_r <= '0;
            internal_fast_osc_ready <= 1'b0;
            crystal_fast_osc_ready <= 1'b0;
        end else begin
            osc_run_d_r <= osc_run;
            if (!osc_run[0] || !osc_run_d_r[0]) begin
                irc_cnt_r <= '0;
                internal_fast_osc_ready <= 1'b0;
            end else if (irc_cnt_r == ($bits(irc_cnt_r))'(STAB_CYC)) begin
                internal_fast_osc_ready <= 1'b1;
            end else begin
                irc_cnt_r <= irc_cnt_r + 1'b1;
            end
            if (!osc_run[1] || !osc_run_d_r[1]) begin
                xtal_cnt_r <= '0;
                crystal_fast_osc_ready <= 1'b0;
            end else if (xtal_cnt_r == ($bits(xtal_cnt_r))'(STAB_CYC)) begin
                crystal_fast_osc_ready <= 1'b1;
            end else begin
                xtal_cnt_r <= xtal_cnt_r + 1'b1;
            end
        end
    end

    logic fast_ready;
    assign fast_ready = fhs_sel ? crystal_fast_osc_ready
        : internal_fast_osc_ready;

    ////////////////////////////////////////////////////////////////////////
    // system clock select: slow to fast waits for ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_clock_divider_select <= PMSWC_SCC_RST[7:5];
            sys_clk_is_slow <= 1'b0;
        end else if (cks_sel == PMSWC_CKS_SLOW) begin
            sys_clock_divider_select <= cks_sel;
            sys_clk_is_slow <= 1'b1;
        end else if (fast_ready) begin
            sys_clock_divider_select <= cks_sel;
            sys_clk_is_slow <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt / wake sequencer
    logic irq_masked_r;
    logic irq_wake, any_wake;
    assign irq_wake = core_irq.irq_req && !irq_masked_r;
    assign any_wake = pa_wake || irq_wake || wdt_ovf;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PMSWC_RUN;
            irq_masked_r <= 1'b0;
            resume_after_halt <= 1'b0;
            irq_take <= 1'b0;
            pc_sp_reset <= 1'b0;
        end else begin
            resume_after_halt <= 1'b0;
            irq_take <= 1'b0;
            pc_sp_reset <= 1'b0;
            case (state_r)
                PMSWC_RUN: begin
                    if (halt_cmd) begin
                        state_r <= PMSWC_HALTED;
                        irq_masked_r <= core_irq.irq_req;
                    end
                end
                PMSWC_HALTED: begin
                    if (any_wake) begin
                        state_r <= PMSWC_WAKE;
                    end
                end
                PMSWC_WAKE: begin
                    // only wait for the oscillator actually in use
                    if (sys_clk_is_slow || fast_ready) begin
                        state_r <= PMSWC_RESUME;
                    end
                end
                PMSWC_RESUME: begin
                    state_r <= PMSWC_RUN;
                    irq_masked_r <= 1'b0;
                    if (watchdog_timeout_flag) begin
                        pc_sp_reset <= 1'b1;
                    end else if (core_irq.irq_req && core_irq.irq_enabled
                        && !core_irq.stack_full) begin
                        irq_take <= 1'b1;
                    end else begin
                        resume_after_halt <= 1'b1;
                    end
                end
                default: state_r <= PMSWC_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags; halt also clears the watchdog counter, software registers untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (halt_cmd && state_r == PMSWC_RUN) begin
                power_down_flag <= 1'b1;
                watchdog_timeout_flag <= 1'b0;
            end else begin
                if (clrwdt_cmd) begin
                    power_down_flag <= 1'b0;
                    watchdog_timeout_flag <= 1'b0;
                end
                if (wdt_ovf && state_r == PMSWC_HALTED) begin
                    watchdog_timeout_flag <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_ctrl <= '{fast_clk_en: 1'b1, slow_clk_en: 1'b1,
                sys_clk_en: 1'b1, cpu_hold: 1'b0};
        end else if (state_r == PMSWC_HALTED) begin
            // sleep, idle slow, idle both, idle fast
            clk_ctrl.fast_clk_en <= fast_keep_in_idle;
            clk_ctrl.slow_clk_en <= slow_keep_in_idle;
            clk_ctrl.sys_clk_en <= 1'b0;
            clk_ctrl.cpu_hold <= 1'b1;
        end else begin
            clk_ctrl.fast_clk_en <= 1'b1;
            clk_ctrl.slow_clk_en <= 1'b1;
            clk_ctrl.sys_clk_en <= state_r == PMSWC_RUN;
            clk_ctrl.cpu_hold <= state_r != PMSWC_RUN;
        end
    end
endmodule : pmswc_top
`default_nettype wire

// ### hw/pmswc_pkg.sv
package pmswc_pkg;
    // register byte offsets
    localparam logic [7:0] PMSWC_SCC_OFF = 8'h00;
    localparam logic [7:0] PMSWC_OSC_OFF = 8'h04;
    localparam logic [7:0] PMSWC_STAT_OFF = 8'h08;
    localparam logic [7:0] PMSWC_PORT_A_WAKE_ENABLE_OFF = 8'h0C;
    localparam logic [7:0] PMSWC_WDT_OFF = 8'h10;
    localparam logic [7:0] PMSWC_CMD_OFF = 8'h14;
    // system clock control field positions
    localparam int PMSWC_CKS_LSB = 5;
    localparam int PMSWC_FHS_BIT = 3;
    localparam int PMSWC_FSS_BIT = 2;
    localparam int PMSWC_FKEEP_BIT = 1;
    localparam int PMSWC_SKEEP_BIT = 0;
    localparam logic [7:0] PMSWC_SCC_RST = 8'h00;
    localparam logic [7:0] PMSWC_SCC_WMASK = 8'hEF;
    localparam logic [2:0] PMSWC_CKS_SLOW = 3'h7;
    // oscillator control: bit0 internal enable, bit1 crystal enable
    localparam logic [1:0] PMSWC_OSC_RST = 2'h1;
    // watchdog control
    localparam logic [4:0] PMSWC_WE_DIS = 5'h15;
    localparam logic [4:0] PMSWC_WE_EN = 5'h0A;
    localparam logic [7:0] PMSWC_WDTC_RST = 8'h53;
    // command register bits
    localparam int PMSWC_CMD_HALT = 0;
    localparam int PMSWC_CMD_CLRWDT = 1;
    // timing
    localparam int PMSWC_CLK_MHZ = 250;
    localparam int PMSWC_OSC_STAB_US = 64;
    localparam int PMSWC_OSC_STAB_CYC = PMSWC_OSC_STAB_US * PMSWC_CLK_MHZ;
    localparam int PMSWC_SLOW_DIV = 8;

    typedef enum logic [3:0] {
        PMSWC_RUN = 4'b0001,
        PMSWC_HALTED = 4'b0010,
        PMSWC_WAKE = 4'b0100,
        PMSWC_RESUME = 4'b1000
    } pmswc_state_t;

    typedef enum logic [2:0] {
        PMSWC_M_SLEEP = 3'd0,
        PMSWC_M_IDLE_SLOW = 3'd1,
        PMSWC_M_IDLE_BOTH = 3'd2,
        PMSWC_M_IDLE_FAST = 3'd3,
        PMSWC_M_ACTIVE = 3'd4
    } pmswc_mode_t;

    typedef struct packed {
        logic fast_clk_en;
        logic slow_clk_en;
        logic sys_clk_en;
        logic cpu_hold;
    } pmswc_clk_t;

    typedef struct packed {
        logic irq_req;
        logic irq_enabled;
        logic stack_full;
    } pmswc_irq_t;
endpackage : pmswc_pkg

// ### test/pmswc_props.sv
`timescale 1ns/1ns
`default_nettype none
module pmswc_props
    import pmswc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pmswc_irq_t core_irq,
    input wire pmswc_clk_t clk_ctrl,
    input wire logic [2:0] sys_clock_divider_select,
    input wire logic sys_clk_is_slow,
    input wire logic resume_after_halt,
    input wire logic irq_take,
    input wire logic pc_sp_reset
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_pulse_excl;
        $onehot0({resume_after_halt, irq_take, pc_sp_reset});
    endproperty
    a_pulse_excl: assert property (p_pulse_excl)
        else $error("two wake outcomes at once");
    property p_slow_sel;
        sys_clk_is_slow == (sys_clock_divider_select == PMSWC_CKS_SLOW);
    endproperty
    a_slow_sel: assert property (p_slow_sel)
        else $error("slow flag disagrees with select code");
    property p_sys_hold;
        !clk_ctrl.sys_clk_en |-> clk_ctrl.cpu_hold;
    endproperty
    a_sys_hold: assert property (p_sys_hold)
        else $error("system clock stopped while core runs");
    property p_sleep_sys;
        !clk_ctrl.fast_clk_en && !clk_ctrl.slow_clk_en |-> !clk_ctrl.sys_clk_en;
    endproperty
    a_sleep_sys: assert property (p_sleep_sys)
        else $error("system clock runs with both oscillators off");
    property p_irq_cause;
        irq_take |-> $past(core_irq.irq_enabled) && !$past(core_irq.stack_full);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt taken while masked or stack full");
    property p_res_pulse;
        resume_after_halt |=> !resume_after_halt [*2];
    endproperty
    a_res_pulse: assert property (p_res_pulse)
        else $error("resume pulse too long");
    property p_pcsp_pulse;
        pc_sp_reset |=> !pc_sp_reset && !irq_take && !resume_after_halt;
    endproperty
    a_pcsp_pulse: assert property (p_pcsp_pulse)
        else $error("watchdog wake pulse not single");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before taken");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped before taken");
endmodule : pmswc_props
bind pmswc_top pmswc_props u_props (.aclk, .aresetn, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .core_irq, .clk_ctrl, .sys_clock_divider_select,
    .sys_clk_is_slow, .resume_after_halt, .irq_take, .pc_sp_reset);
`default_nettype wire

// ### test/pmswc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmswc_core_model
    import pmswc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic want_req,
    input wire logic want_en,
    input wire logic want_full,
    input wire logic irq_take,
    output pmswc_irq_t core_irq
);
    logic served_r;
    // a serviced request drops, an unserviced one stays pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            served_r <= 1'b0;
            core_irq <= '0;
        end else begin
            served_r <= (served_r | irq_take) & want_req;
            core_irq.irq_req <= want_req & ~served_r & ~irq_take;
            core_irq.irq_enabled <= want_en;
            core_irq.stack_full <= want_full;
        end
    end
endmodule : pmswc_core_model
`default_nettype wire

// ### test/tb_power_mode_sleep_wake_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_power_mode_sleep_wake_control;
    import pmswc_pkg::*;
    localparam int STAB = 16;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, port_a_in = 8'hff;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, want_req = 0;
    logic want_en = 0, want_full = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sys_clk_is_slow, resume_after_halt, irq_take;
    logic pc_sp_reset;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] sys_clock_divider_select;
    pmswc_irq_t core_irq;
    pmswc_clk_t clk_ctrl;
    int miscompares = 0, total_checks = 0, n_res = 0, n_irq = 0, n_pcs = 0;
    int pe, pd, cyc, kind, per;
    logic [31:0] d;
    always #2 aclk = ~aclk;
    pmswc_top #(.STAB_CYC(STAB), .WDT_W(8)) dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port_a_in, .core_irq, .clk_ctrl,
        .sys_clock_divider_select, .sys_clk_is_slow, .resume_after_halt,
        .irq_take, .pc_sp_reset);
    pmswc_core_model core (.aclk, .aresetn, .want_req, .want_en,
        .want_full, .irq_take, .core_irq);
    always @(posedge aclk) begin
        n_res <= n_res + int'(resume_after_halt === 1'b1);
        n_irq <= n_irq + int'(irq_take === 1'b1);
        n_pcs <= n_pcs + int'(pc_sp_reset === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] er = 2'b00);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bready | 1'($urandom % 2);
        end
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rready | 1'($urandom % 2);
        end
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        logic [31:0] v;
        rd(a, v, 2'b00);
        chk(v & m, e);
    endtask : rchk
    task automatic wake(output int c, output int k);
        int r0, i0, p0;
        r0 = n_res;
        i0 = n_irq;
        p0 = n_pcs;
        c = 0;
        while (n_res == r0 && n_irq == i0 && n_pcs == p0 && c < 5000) begin
            @(posedge aclk);
            c++;
        end
        k = (n_res != r0) ? 1 : (n_irq != i0) ? 2 : (n_pcs != p0) ? 3 : 0;
    endtask : wake
    task automatic stop_test;
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 60000);
        miscompares++;
        stop_test();
    end
    initial begin
        void'($urandom(58063));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(PMSWC_SCC_OFF, 32'h0, 32'hffff_ffff);
        rchk(PMSWC_WDT_OFF, 32'h53, 32'hff);
        rchk(PMSWC_STAT_OFF, 32'h0, 32'h3);
        rd(8'h18, d, 2'b10);
        chk(d, 32'h0);
        wr(8'h18, 32'h0, 2'b10);
        repeat (STAB + 4) @(posedge aclk);
        rchk(PMSWC_OSC_OFF, 32'h5, 32'h7);
        wr(PMSWC_OSC_OFF, 32'h3);
        for (int c = 0; c < 8; c++) begin
            wr(PMSWC_SCC_OFF, 32'(c * 32 + 16));
            repeat (8) @(posedge aclk);
            chk(32'(sys_clock_divider_select), 32'(c));
            chk(32'(sys_clk_is_slow), 32'(c == 7));
            rchk(PMSWC_SCC_OFF, 32'(c * 32), 32'hffff_ffff);
        end
        rchk(PMSWC_OSC_OFF, 32'hf, 32'hf);
        wr(PMSWC_OSC_OFF, 32'h0);
        wr(PMSWC_SCC_OFF, 32'h60);
        repeat (8) @(posedge aclk);
        chk(32'(sys_clock_divider_select), 32'h7);
        wr(PMSWC_OSC_OFF, 32'h1);
        rchk(PMSWC_OSC_OFF, 32'h1, 32'h7);
        d = 0;
        for (int i = 0; i < 50 && d[2] !== 1'b1; i++) rd(PMSWC_OSC_OFF, d, 2'b00);
        repeat (8) @(posedge aclk);
        chk(32'(sys_clock_divider_select), 32'h3);
        pe = $urandom % 8;
        pd = (pe + 1 + $urandom % 7) % 8;
        wr(PMSWC_PORT_A_WAKE_ENABLE_OFF, 32'(($urandom | (1 << pe)) & ~(1 << pd) & 8'hff));
        for (int k = 0; k < 4; k++) begin
            want_en <= (k != 2);
            want_full <= (k == 3);
            wr(PMSWC_SCC_OFF, 32'(k));
            wr(PMSWC_CMD_OFF, 32'h1);
            repeat (4) @(posedge aclk);
            chk({clk_ctrl.fast_clk_en, clk_ctrl.slow_clk_en, clk_ctrl.cpu_hold},
                {k[1], k[0], 1'b1});
            if (k == 0) chk(32'(clk_ctrl.sys_clk_en), 32'h0);
            rchk(PMSWC_STAT_OFF, 32'h22, 32'h33);
            if (k == 0) begin
                port_a_in[pd] <= 1'b0;
                repeat (10) @(posedge aclk);
                chk(32'(clk_ctrl.cpu_hold), 32'h1);
                port_a_in[pe] <= 1'b0;
            end else begin
                want_req <= 1'b1;
            end
            wake(cyc, kind);
            chk(32'(kind), (k == 1) ? 32'h2 : 32'h1);
            if (k == 0) chk(32'(cyc >= STAB), 32'h1);
            want_req <= 1'b0;
            port_a_in <= 8'hff;
            repeat (4) @(posedge aclk);
            chk(32'(clk_ctrl.cpu_hold), 32'h0);
            rchk(PMSWC_SCC_OFF, 32'(k), 32'hffff_ffff);
            rchk(PMSWC_STAT_OFF, 32'h2, 32'h23);
        end
        want_full <= 1'b0;
        want_req <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(PMSWC_CMD_OFF, 32'h1);
        repeat (30) @(posedge aclk);
        chk(32'(clk_ctrl.cpu_hold), 32'h1);
        port_a_in[pe] <= 1'b0;
        wake(cyc, kind);
        chk(32'(kind), 32'h2);
        want_req <= 1'b0;
        port_a_in <= 8'hff;
        wr(PMSWC_CMD_OFF, 32'h2);
        rchk(PMSWC_STAT_OFF, 32'h0, 32'h2);
        wr(PMSWC_CMD_OFF, 32'h1);
        wake(per, kind);
        chk(32'(kind), 32'h3);
        rchk(PMSWC_STAT_OFF, 32'h3, 32'h3);
        wr(PMSWC_CMD_OFF, 32'h2);
        repeat (per * 3 / 4) @(posedge aclk);
        wr(PMSWC_CMD_OFF, 32'h1);
        wake(cyc, kind);
        chk(32'(cyc > per / 2), 32'h1);
        wr(PMSWC_WDT_OFF, 32'ha8);
        wr(PMSWC_CMD_OFF, 32'h1);
        repeat (per + per / 2) @(posedge aclk);
        chk(32'(clk_ctrl.cpu_hold), 32'h1);
        port_a_in[pe] <= 1'b0;
        wake(cyc, kind);
        chk(32'(kind), 32'h1);
        stop_test();
    end
endmodule : tb_power_mode_sleep_wake_control
`default_nettype wire
